// File: logic/tcp_pkg.sv
// constants and types shared by the timer and its prescaler
package tcp_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int PSC_W = 10;
    localparam int NUM_TIMERS = 2;

    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_COUNTER = 8'h04;
    localparam logic [7:0] OFF_COMPARE = 8'h08;
    localparam logic [7:0] OFF_MASK = 8'h0C;
    localparam logic [7:0] OFF_FLAGS = 8'h10;
    localparam logic [7:0] OFF_PSC = 8'h14;

    localparam int CTRL_FORCE_BIT = 7;
    localparam int CTRL_WGM0_BIT = 6;
    localparam int CTRL_COM_LSB = 4;
    localparam int CTRL_WGM1_BIT = 3;
    localparam int CTRL_CS_LSB = 0;
    localparam logic [7:0] CTRL_WR_MASK = 8'h7F;
    localparam int IRQ_CMP_BIT = 1;
    localparam int IRQ_OVF_BIT = 0;
    localparam int PSC_HOLD_BIT = 7;
    localparam int PSC_RST_BIT = 0;

    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] COUNTER_RST = 8'h00;
    localparam logic [7:0] COMPARE_RST = 8'h00;
    localparam logic [1:0] MASK_RST = 2'h0;
    localparam logic [1:0] FLAGS_RST = 2'h0;
    localparam logic [PSC_W-1:0] PSC_CNT_RST = 10'h000;

    localparam logic [1:0] WGM_NORMAL = 2'h0;
    localparam logic [1:0] WGM_PCPWM = 2'h1;
    localparam logic [1:0] WGM_CTC = 2'h2;
    localparam logic [1:0] WGM_FAST = 2'h3;

    localparam logic [1:0] COM_OFF = 2'h0;
    localparam logic [1:0] COM_TOGGLE = 2'h1;
    localparam logic [1:0] COM_CLEAR = 2'h2;
    localparam logic [1:0] COM_SET = 2'h3;

    localparam logic [2:0] CS_STOP = 3'h0;
    localparam logic [2:0] CS_DIV1 = 3'h1;
    localparam logic [2:0] CS_DIV8 = 3'h2;
    localparam logic [2:0] CS_DIV64 = 3'h3;
    localparam logic [2:0] CS_DIV256 = 3'h4;
    localparam logic [2:0] CS_DIV1024 = 3'h5;
    localparam logic [2:0] CS_EXT_FALL = 3'h6;
    localparam logic [2:0] CS_EXT_RISE = 3'h7;

    localparam logic [7:0] CNT_BOTTOM = 8'h00;
    localparam logic [7:0] CNT_MAX = 8'hFF;

    typedef enum logic {TCP_DIR_UP, TCP_DIR_DOWN} tcp_dir_t;
endpackage : tcp_pkg

// File: logic/tcp_presc_if.sv
// carrier between the timer and the shared prescaler
`timescale 1ns/1ns
interface tcp_presc_if;
    logic presc_rst;
    logic [tcp_pkg::NUM_TIMERS-1:0][2:0] clk_sel;
    logic [tcp_pkg::NUM_TIMERS-1:0] tick;
    modport presc (input presc_rst, input clk_sel, output tick);
    modport timer (output presc_rst, output clk_sel, input tick);
endinterface : tcp_presc_if

// File: logic/tcp_prescaler.sv
// free-running prescaler shared by two timers
`timescale 1ns/1ns
module tcp_prescaler (
    input wire logic pclk,
    input wire logic presetn,
    tcp_presc_if.presc pif
);
    typedef struct packed {
        logic [tcp_pkg::PSC_W-1:0] cnt;
        logic [tcp_pkg::NUM_TIMERS-1:0] tick;
    } tcp_psc_state_t;

    tcp_psc_state_t st_r;
    tcp_psc_state_t st_nxt;

    function automatic logic tcp_tap_hit(input logic [2:0] sel,
                                         input logic [tcp_pkg::PSC_W-1:0] c);
        case (sel)
            tcp_pkg::CS_DIV1: tcp_tap_hit = 1'b1;
            tcp_pkg::CS_DIV8: tcp_tap_hit = &c[2:0];
            tcp_pkg::CS_DIV64: tcp_tap_hit = &c[5:0];
            tcp_pkg::CS_DIV256: tcp_tap_hit = &c[7:0];
            tcp_pkg::CS_DIV1024: tcp_tap_hit = &c[9:0];
            default: tcp_tap_hit = 1'b0;
        endcase
    endfunction : tcp_tap_hit

    always_comb begin
        st_nxt = st_r;
        // never gated by clock select, so first count lands 1..N cycles late
        if (pif.presc_rst) begin
            st_nxt.cnt = tcp_pkg::PSC_CNT_RST;
        end else begin
            st_nxt.cnt = st_r.cnt + 10'h001;
        end
        for (int i = 0; i < tcp_pkg::NUM_TIMERS; i++) begin
            // each timer picks its own tap from the one counter
            st_nxt.tick[i] = tcp_tap_hit(pif.clk_sel[i], st_r.cnt)
                && (!pif.presc_rst || pif.clk_sel[i] == tcp_pkg::CS_DIV1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '{cnt: tcp_pkg::PSC_CNT_RST, tick: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign pif.tick = st_r.tick;
endmodule : tcp_prescaler

// File: logic/tcp_timer0.sv
// 8-bit timer with one compare channel, APB registers and shared prescaler
`timescale 1ns/1ns
module tcp_timer0 (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [tcp_pkg::ADDR_W-1:0] paddr,
    input wire logic [tcp_pkg::DATA_W-1:0] pwdata,
    output logic [tcp_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic external_count_input,
    input wire logic port_data_out,
    input wire logic port_dir_out,
    output logic compare_output_pin,
    output logic compare_output_pin_oe,
    input wire logic global_interrupt_enable,
    input wire logic compare_irq_ack,
    input wire logic overflow_irq_ack,
    output logic compare_irq_req,
    output logic overflow_irq_req,
    input wire logic [2:0] timer1_clock_select,
    output logic timer1_tick
);
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] cnt;
        logic [7:0] cmp_buf;
        logic [7:0] cmp_act;
        logic [1:0] mask;
        logic [1:0] flags;
        logic sync_hold;
        logic psc_rst;
        tcp_pkg::tcp_dir_t dir;
        logic oc;
        logic blk;
        logic ext_s1;
        logic ext_s2;
        logic ext_s3;
        logic pin_o;
        logic pin_oe;
        logic cmp_irq;
        logic ovf_irq;
        logic rdy;
        logic err;
        logic [tcp_pkg::DATA_W-1:0] rdata;
    } tcp_tmr_state_t;

    localparam tcp_tmr_state_t ST_RST = '{
        ctrl: tcp_pkg::CTRL_RST,
        cnt: tcp_pkg::COUNTER_RST,
        cmp_buf: tcp_pkg::COMPARE_RST,
        cmp_act: tcp_pkg::COMPARE_RST,
        mask: tcp_pkg::MASK_RST,
        flags: tcp_pkg::FLAGS_RST,
        dir: tcp_pkg::TCP_DIR_UP,
        default: '0
    };

    tcp_tmr_state_t st_r;
    tcp_tmr_state_t st_nxt;
    tcp_presc_if pif ();

    logic [1:0] waveform_mode_sel;
    logic [1:0] compare_output_mode;
    logic [2:0] clock_select_field;
    logic tick;
    logic match_ev;
    logic ovf_ev;
    logic top_ev;
    logic special;
    logic setup_ph;
    logic wr_acc;
    logic [1:0] flag_clr;

    assign waveform_mode_sel = {st_r.ctrl[tcp_pkg::CTRL_WGM1_BIT],
        st_r.ctrl[tcp_pkg::CTRL_WGM0_BIT]};
    assign compare_output_mode = st_r.ctrl[tcp_pkg::CTRL_COM_LSB +: 2];
    assign clock_select_field = st_r.ctrl[tcp_pkg::CTRL_CS_LSB +: 3];
    assign pif.presc_rst = st_r.psc_rst;
    assign pif.clk_sel[0] = clock_select_field;
    assign pif.clk_sel[1] = timer1_clock_select;

    tcp_prescaler u_presc (
        .pclk(pclk),
        .presetn(presetn),
        .pif(pif)
    );

    // timer clock: prescaler tap or synchronised external edge
    always_comb begin
        case (clock_select_field)
            tcp_pkg::CS_STOP: tick = 1'b0;
            tcp_pkg::CS_EXT_FALL: tick = st_r.ext_s3 && !st_r.ext_s2;
            tcp_pkg::CS_EXT_RISE: tick = !st_r.ext_s3 && st_r.ext_s2;
            default: tick = pif.tick[0];
        endcase
    end

    assign setup_ph = psel && !penable;
    assign wr_acc = psel && penable && st_r.rdy && pwrite && !st_r.err;
    assign match_ev = tick && !st_r.blk && (st_r.cnt == st_r.cmp_act);
    assign special = compare_output_mode[1] && (st_r.cmp_act == tcp_pkg::CNT_MAX);
    assign flag_clr = {compare_irq_ack, overflow_irq_ack}
        | ((wr_acc && paddr == tcp_pkg::OFF_FLAGS) ? pwdata[1:0] : 2'h0);

    always_comb begin
        st_nxt = st_r;
        ovf_ev = 1'b0;
        top_ev = 1'b0;

        // two-flop sync; no dependence on the pin's direction
        st_nxt.ext_s1 = external_count_input;
        st_nxt.ext_s2 = st_r.ext_s1;
        st_nxt.ext_s3 = st_r.ext_s2;

        if (tick) begin
            st_nxt.blk = 1'b0;
            case (waveform_mode_sel)
                tcp_pkg::WGM_PCPWM: begin
                    if (st_r.dir == tcp_pkg::TCP_DIR_UP) begin
                        if (st_r.cnt == tcp_pkg::CNT_MAX) begin
                            top_ev = 1'b1;
                            st_nxt.dir = tcp_pkg::TCP_DIR_DOWN;
                            st_nxt.cnt = st_r.cnt - 8'h01;
                        end else begin
                            st_nxt.cnt = st_r.cnt + 8'h01;
                        end
                    end else begin
                        if (st_r.cnt == tcp_pkg::CNT_BOTTOM) begin
                            ovf_ev = 1'b1;
                            st_nxt.dir = tcp_pkg::TCP_DIR_UP;
                            st_nxt.cnt = st_r.cnt + 8'h01;
                        end else begin
                            st_nxt.cnt = st_r.cnt - 8'h01;
                        end
                    end
                end
                tcp_pkg::WGM_CTC: begin
                    ovf_ev = (st_r.cnt == tcp_pkg::CNT_MAX);
                    st_nxt.cnt = (st_r.cnt == st_r.cmp_act) ? tcp_pkg::CNT_BOTTOM
                                                            : st_r.cnt + 8'h01;
                end
                default: begin
                    ovf_ev = (st_r.cnt == tcp_pkg::CNT_MAX);
                    st_nxt.cnt = st_r.cnt + 8'h01;
                end
            endcase
        end

        // waveform generator
        case (waveform_mode_sel)
            tcp_pkg::WGM_FAST: begin
                if (match_ev && !special && compare_output_mode[1]) begin
                    st_nxt.oc = (compare_output_mode == tcp_pkg::COM_SET);
                end
                if (ovf_ev && compare_output_mode[1]) begin
                    st_nxt.oc = (compare_output_mode == tcp_pkg::COM_CLEAR);
                end
            end
            tcp_pkg::WGM_PCPWM: begin
                if (special) begin
                    if (top_ev) begin
                        st_nxt.oc = (compare_output_mode == tcp_pkg::COM_CLEAR);
                    end
                end else if (match_ev && compare_output_mode[1]) begin
                    if (st_r.dir == tcp_pkg::TCP_DIR_UP) begin
                        st_nxt.oc = (compare_output_mode == tcp_pkg::COM_SET);
                    end else begin
                        st_nxt.oc = (compare_output_mode == tcp_pkg::COM_CLEAR);
                    end
                end
            end
            default: begin
                if (match_ev) begin
                    case (compare_output_mode)
                        tcp_pkg::COM_TOGGLE: st_nxt.oc = !st_r.oc;
                        tcp_pkg::COM_CLEAR: st_nxt.oc = 1'b0;
                        tcp_pkg::COM_SET: st_nxt.oc = 1'b1;
                        default: st_nxt.oc = st_r.oc;
                    endcase
                end
            end
        endcase

        // double buffer: pwm modes load at top or bottom only, avoiding glitches
        if (waveform_mode_sel == tcp_pkg::WGM_FAST && ovf_ev) begin
            st_nxt.cmp_act = st_r.cmp_buf;
        end
        if (waveform_mode_sel == tcp_pkg::WGM_PCPWM && top_ev) begin
            st_nxt.cmp_act = st_r.cmp_buf;
        end

        // set wins over a clear in the same cycle
        st_nxt.flags[tcp_pkg::IRQ_CMP_BIT] = (st_r.flags[tcp_pkg::IRQ_CMP_BIT]
            && !flag_clr[tcp_pkg::IRQ_CMP_BIT]) || match_ev;
        st_nxt.flags[tcp_pkg::IRQ_OVF_BIT] = (st_r.flags[tcp_pkg::IRQ_OVF_BIT]
            && !flag_clr[tcp_pkg::IRQ_OVF_BIT]) || ovf_ev;

        if (st_r.psc_rst && !st_r.sync_hold) begin
            st_nxt.psc_rst = 1'b0;
        end

        // register writes, taken at the access edge
        if (wr_acc) begin
            case (paddr)
                tcp_pkg::OFF_CTRL: begin
                    st_nxt.ctrl = pwdata[7:0] & tcp_pkg::CTRL_WR_MASK;
                    // forced match: non-pwm only, no flag, no ctc clear
                    if (pwdata[tcp_pkg::CTRL_FORCE_BIT] && !pwdata[tcp_pkg::CTRL_WGM0_BIT]) begin
                        case (pwdata[tcp_pkg::CTRL_COM_LSB +: 2])
                            tcp_pkg::COM_TOGGLE: st_nxt.oc = !st_r.oc;
                            tcp_pkg::COM_CLEAR: st_nxt.oc = 1'b0;
                            tcp_pkg::COM_SET: st_nxt.oc = 1'b1;
                            default: st_nxt.oc = st_r.oc;
                        endcase
                    end
                end
                tcp_pkg::OFF_COUNTER: begin
                    st_nxt.cnt = pwdata[7:0];
                    st_nxt.blk = 1'b1;
                end
                tcp_pkg::OFF_COMPARE: st_nxt.cmp_buf = pwdata[7:0];
                tcp_pkg::OFF_MASK: st_nxt.mask = pwdata[1:0];
                tcp_pkg::OFF_PSC: begin
                    st_nxt.sync_hold = pwdata[tcp_pkg::PSC_HOLD_BIT];
                    st_nxt.psc_rst = pwdata[tcp_pkg::PSC_RST_BIT];
                end
                default: st_nxt.cmp_buf = st_nxt.cmp_buf;
            endcase
        end
        if (!waveform_mode_sel[0]) begin
            st_nxt.cmp_act = st_nxt.cmp_buf;
        end

        // apb: one wait-free access phase; read data captured in setup
        st_nxt.rdy = setup_ph;
        st_nxt.err = 1'b0;
        st_nxt.rdata = '0;
        if (setup_ph) begin
            case (paddr)
                tcp_pkg::OFF_CTRL: st_nxt.rdata[7:0] = st_r.ctrl;
                tcp_pkg::OFF_COUNTER: st_nxt.rdata[7:0] = st_r.cnt;
                tcp_pkg::OFF_COMPARE: st_nxt.rdata[7:0] = st_r.cmp_buf;
                tcp_pkg::OFF_MASK: st_nxt.rdata[1:0] = st_r.mask;
                tcp_pkg::OFF_FLAGS: st_nxt.rdata[1:0] = st_r.flags;
                tcp_pkg::OFF_PSC: begin
                    st_nxt.rdata[tcp_pkg::PSC_HOLD_BIT] = st_r.sync_hold;
                    st_nxt.rdata[tcp_pkg::PSC_RST_BIT] = st_r.psc_rst;
                end
                default: st_nxt.err = 1'b1;
            endcase
        end

        st_nxt.pin_o = (compare_output_mode != tcp_pkg::COM_OFF) ? st_r.oc : port_data_out;
        st_nxt.pin_oe = port_dir_out;
        st_nxt.cmp_irq = global_interrupt_enable && st_r.mask[tcp_pkg::IRQ_CMP_BIT]
            && st_r.flags[tcp_pkg::IRQ_CMP_BIT];
        st_nxt.ovf_irq = global_interrupt_enable && st_r.mask[tcp_pkg::IRQ_OVF_BIT]
            && st_r.flags[tcp_pkg::IRQ_OVF_BIT];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= ST_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign prdata = st_r.rdata;
    assign pready = st_r.rdy;
    assign pslverr = st_r.err;
    assign compare_output_pin = st_r.pin_o;
    assign compare_output_pin_oe = st_r.pin_oe;
    assign compare_irq_req = st_r.cmp_irq;
    assign overflow_irq_req = st_r.ovf_irq;
    assign timer1_tick = pif.tick[1];

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_pin_select: assert property ((compare_output_mode != tcp_pkg::COM_OFF)
        |=> compare_output_pin == $past(st_r.oc))
        else $error("pin not driven by compare output");
    // skip the edge that leaves reset: the flop is still held there
    a_pin_enable: assert property ($past(presetn)
        |-> compare_output_pin_oe == $past(port_dir_out))
        else $error("pin enable does not follow direction");
    a_toggle_match: assert property ((waveform_mode_sel == tcp_pkg::WGM_NORMAL
        && compare_output_mode == tcp_pkg::COM_TOGGLE && match_ev && !wr_acc)
        |=> st_r.oc != $past(st_r.oc))
        else $error("toggle on match missing");
    a_fast_bottom: assert property ((waveform_mode_sel == tcp_pkg::WGM_FAST
        && compare_output_mode == tcp_pkg::COM_CLEAR && ovf_ev && !wr_acc) |=> st_r.oc)
        else $error("fast pwm bottom set missing");
    a_fast_top_ignore: assert property ((waveform_mode_sel == tcp_pkg::WGM_FAST
        && special && match_ev && !wr_acc)
        |=> st_r.oc == $past(compare_output_mode == tcp_pkg::COM_CLEAR))
        else $error("match at top not ignored");
    a_pc_up_clear: assert property ((waveform_mode_sel == tcp_pkg::WGM_PCPWM
        && compare_output_mode == tcp_pkg::COM_CLEAR && !special && match_ev
        && st_r.dir == tcp_pkg::TCP_DIR_UP && !wr_acc) |=> !st_r.oc)
        else $error("phase correct up match did not clear");
    a_pc_top_action: assert property ((waveform_mode_sel == tcp_pkg::WGM_PCPWM
        && special && top_ev && !wr_acc)
        |=> st_r.oc == $past(compare_output_mode == tcp_pkg::COM_CLEAR))
        else $error("phase correct top action missing");
    a_stop_hold: assert property ((clock_select_field == tcp_pkg::CS_STOP && !wr_acc)
        |=> $stable(st_r.cnt))
        else $error("stopped counter moved");
    a_write_block: assert property ((wr_acc && paddr == tcp_pkg::OFF_COUNTER)
        |=> st_r.blk && !match_ev)
        else $error("match not blocked after write");
    a_cmp_flag: assert property (match_ev |=> st_r.flags[tcp_pkg::IRQ_CMP_BIT])
        else $error("compare flag not set");
    a_ovf_req: assert property ((global_interrupt_enable
        && st_r.mask[tcp_pkg::IRQ_OVF_BIT] && st_r.flags[tcp_pkg::IRQ_OVF_BIT])
        |=> ##[0:1] overflow_irq_req)
        else $error("overflow request missing");
    a_cmp_req: assert property (compare_irq_req
        |-> $past(global_interrupt_enable && st_r.flags[tcp_pkg::IRQ_CMP_BIT]))
        else $error("compare request without cause");
    a_psc_clear: assert property ((st_r.psc_rst && !st_r.sync_hold && !wr_acc)
        |=> !st_r.psc_rst)
        else $error("prescaler reset did not self clear");

    c_pc_ovf: cover property (waveform_mode_sel == tcp_pkg::WGM_PCPWM && ovf_ev);
    c_fast_match: cover property (waveform_mode_sel == tcp_pkg::WGM_FAST && match_ev);
    c_ext_count: cover property (clock_select_field == tcp_pkg::CS_EXT_RISE && tick);
    c_set_clear: cover property (match_ev && flag_clr[tcp_pkg::IRQ_CMP_BIT]);
endmodule : tcp_timer0

// File: verification/tb_tcp_timer0.sv
// self-checking bench for the 8-bit timer through its register bus
`timescale 1ns/1ns
module tb_tcp_timer0;
    logic pclk, presetn, psel, penable, pwrite, ext, pdo, pdir, gie, cack, oack;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, pin, oe, creq, oreq, t1tick, rerr;
    logic [2:0] t1cs;
    int errors, n_checks, k;
    tcp_timer0 dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .external_count_input(ext), .port_data_out(pdo),
        .port_dir_out(pdir), .compare_output_pin(pin), .compare_output_pin_oe(oe),
        .global_interrupt_enable(gie), .compare_irq_ack(cack), .overflow_irq_ack(oack),
        .compare_irq_req(creq), .overflow_irq_req(oreq), .timer1_clock_select(t1cs),
        .timer1_tick(t1tick));
    initial begin
        pclk = 0;
        forever #4 pclk = ~pclk;
    end
    task tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // request held until pready is sampled high; the edge value is the sampled one
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        if (pready !== 1'b1) begin
            errors++;
            tally_and_finish;
        end
        rd = prdata;
        rerr = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask : apb
    task rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(0, a, 0);
        chk(rd, exp);
    endtask : rdchk
    // poll the flag register with a bounded count
    task poll(input int b);
        int i;
        i = 0;
        do begin
            apb(0, tcp_pkg::OFF_FLAGS, 0);
            i++;
        end while (rd[b] !== 1'b1 && i < 300);
        chk(rd[b], 1);
    endtask : poll
    task edge_ext(input logic v);
        ext <= v;
        repeat (4) @(posedge pclk);
    endtask : edge_ext
    task pin_after(input logic [7:0] ctl, input logic exp);
        apb(1, tcp_pkg::OFF_CTRL, {24'h000000, ctl});
        repeat (2) @(posedge pclk);
        chk(pin, exp);
    endtask : pin_after
    // high cycles of the pin over a window of whole pwm periods
    task count_hi(input int n, input int exp);
        int h;
        h = 0;
        repeat (n) begin
            @(posedge pclk);
            h += (pin === 1'b1);
        end
        chk(h, exp);
    endtask : count_hi
    initial begin
        {psel, penable, pwrite, ext, pdo, gie, cack, oack} = 8'h00;
        pdir = 1;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        t1cs = 3'h0;
        presetn = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        rdchk(tcp_pkg::OFF_COUNTER, 32'h00000000);
        rdchk(tcp_pkg::OFF_FLAGS, 32'h00000000);
        apb(0, 8'h3C, 0);
        chk(rerr, 1);
        chk(rd, 32'h00000000);
        apb(1, tcp_pkg::OFF_COUNTER, 32'h0000005A);
        rdchk(tcp_pkg::OFF_COUNTER, 32'h0000005A);
        rdchk(tcp_pkg::OFF_COUNTER, 32'h0000005A);
        $display("test registers done");
        // force strobes give exact output actions with no timing spread
        pin_after(8'h30, 1'b0);
        pin_after(8'hB0, 1'b1);
        pin_after(8'hA0, 1'b0);
        pin_after(8'h90, 1'b1);
        pin_after(8'h90, 1'b0);
        pdo <= 1;
        pin_after(8'h00, 1'b1);
        chk(oe, 1);
        pdir <= 0;
        repeat (2) @(posedge pclk);
        chk(oe, 0);
        $display("test output modes done");
        apb(1, tcp_pkg::OFF_MASK, 32'h00000003);
        gie <= 1;
        apb(1, tcp_pkg::OFF_COMPARE, 32'h00000010);
        apb(1, tcp_pkg::OFF_COUNTER, 32'h00000005);
        apb(1, tcp_pkg::OFF_CTRL, {26'h0, tcp_pkg::COM_TOGGLE, 1'b0, tcp_pkg::CS_DIV1});
        poll(tcp_pkg::IRQ_CMP_BIT);
        chk(creq, 1);
        chk(pin, 1);
        apb(1, tcp_pkg::OFF_FLAGS, 32'h00000002);
        rdchk(tcp_pkg::OFF_FLAGS, 32'h00000000);
        apb(1, tcp_pkg::OFF_COUNTER, 32'h000000FE);
        poll(tcp_pkg::IRQ_OVF_BIT);
        chk(oreq, 1);
        oack <= 1;
        @(posedge pclk);
        oack <= 0;
        repeat (2) @(posedge pclk);
        chk(oreq, 0);
        $display("test flags done");
        for (k = 0; k < 2; k++) begin
            apb(1, tcp_pkg::OFF_CTRL, {29'h0, k ? tcp_pkg::CS_EXT_FALL : tcp_pkg::CS_EXT_RISE});
            apb(1, tcp_pkg::OFF_COUNTER, 32'h00000000);
            pdir <= 1;
            repeat (3) begin
                edge_ext(1);
                edge_ext(0);
            end
            rdchk(tcp_pkg::OFF_COUNTER, 32'h00000003);
        end
        $display("test external count done");
        apb(1, tcp_pkg::OFF_PSC, 32'h00000001);
        repeat (3) @(posedge pclk);
        rdchk(tcp_pkg::OFF_PSC, 32'h00000000);
        t1cs <= tcp_pkg::CS_DIV8;
        repeat (20) @(posedge pclk);
        n_checks++;
        k = 0;
        repeat (64) begin
            @(posedge pclk);
            k += (t1tick === 1'b1);
        end
        chk(k, 8);
        $display("test prescaler done");
        // fast pwm, clear on match: high for compare+1 of 256 ticks
        apb(1, tcp_pkg::OFF_COMPARE, 32'h0000003F);
        apb(1, tcp_pkg::OFF_CTRL, 32'h00000069);
        repeat (300) @(posedge pclk);
        count_hi(512, 128);
        // phase correct, clear on up match: high 2*compare of 510 ticks
        apb(1, tcp_pkg::OFF_COMPARE, 32'h00000040);
        apb(1, tcp_pkg::OFF_CTRL, 32'h00000061);
        repeat (600) @(posedge pclk);
        count_hi(1020, 256);
        // compare at top: output held high by the top action
        apb(1, tcp_pkg::OFF_COMPARE, 32'h000000FF);
        repeat (1100) @(posedge pclk);
        count_hi(510, 510);
        $display("test pwm done");
        tally_and_finish;
    end
endmodule : tb_tcp_timer0
